// ===== verilog/crt_refresh_pkg.sv
/*
 Shared constants of the character display refresh block: timing chain
 lengths, decode positions, register offsets and field positions.
 Assumes one clock domain and a plain register port on the processor side.
*/
package crt_refresh_pkg;

	// Dot time against the system clock; one dot is a whole number of clocks
	localparam int DOT_PERIOD_PS  = 53800;
	localparam int CLK_PERIOD_PS  = 20000;
	localparam int DOT_CYCLES_RAW = DOT_PERIOD_PS / CLK_PERIOD_PS;
	localparam int DOT_CYCLES     = (DOT_CYCLES_RAW < 1) ? 1 : DOT_CYCLES_RAW;

	// Cell, line and frame geometry
	localparam logic [3:0] DOT_LAST      = 4'h9;
	localparam logic [6:0] CHR_LAST      = 7'h63;
	localparam logic [6:0] VIS_CHARS     = 7'h50;
	localparam logic [6:0] FIRST_VIS     = 7'h02;
	localparam logic [6:0] LAST_VIS      = 7'h51;
	localparam logic [3:0] SCAN_LAST     = 4'hb;
	localparam logic [3:0] SCAN_LAST_60  = 4'h9;
	localparam logic [4:0] VIS_ROWS      = 5'h18;
	localparam logic [4:0] ROW_LAST_60   = 5'h19;
	localparam logic [4:0] ROW_LAST_50   = 5'h1e;

	// Sync decode positions
	localparam logic [6:0] HD_FIRST      = 7'h56;
	localparam logic [6:0] HD_LAST       = 7'h5d;
	localparam logic [4:0] VS_ROW_60     = 5'h19;
	localparam logic [4:0] VS_ROW_50     = 5'h1b;
	localparam logic [3:0] VS_SCANS      = 4'h3;

	// Events within one character cell
	localparam logic [3:0] DOT_FETCH     = 4'h0;
	localparam logic [3:0] DOT_XFER      = 4'h7;
	localparam logic [3:0] DOT_CGA       = 4'h8;

	// Display memory in characters; the last pair before the wrap
	localparam logic [10:0] MEM_LAST_PAIR = 11'h7fe;

	// Display byte layout
	localparam int ATTR_FLAG_BIT  = 7;
	localparam int ATTR_UL_BIT    = 5;
	localparam int ATTR_INV_BIT   = 4;
	localparam int ATTR_DIM_BIT   = 3;
	localparam int ATTR_BLINK_BIT = 2;
	localparam logic [6:0] ATTR_PATTERN = 7'h60;

	// Register map
	localparam logic [1:0] REG_CTRL      = 2'h0;
	localparam logic [1:0] REG_PAGE      = 2'h1;
	localparam logic [1:0] REG_STATUS    = 2'h2;
	localparam int CTRL_WIDE_BIT  = 0;
	localparam int CTRL_HZ50_BIT  = 1;
	localparam logic        CTRL_WIDE_RESET = 1'b0;
	localparam logic        CTRL_HZ50_RESET = 1'b0;
	localparam logic [10:0] PAGE_RESET      = 11'h000;

endpackage : crt_refresh_pkg

// ===== verilog/video_serializer.sv
/*
 Video shift register with field modifier gating.
 Assumes load and shift strikes come from the refresh timing chain on the
 same clock, and that a load never needs a shift in the same cycle.
*/
`timescale 1ns/1ps
module video_serializer (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// Strikes from the timing chain
	input  wire logic       load_in,
	input  wire logic       shift_in,
	// Cell contents
	input  wire logic [6:0] pattern_in,
	input  wire logic       visible_in,
	input  wire logic       underline_in,
	input  wire logic       inverse_in,
	input  wire logic       blink_in,
	input  wire logic       last_scan_in,
	input  wire logic       blink_phase_in,
	// Serial video
	output logic            video_out
);
	typedef struct packed {
		logic [9:0] sh;
		logic       vis;
		logic       ul;
		logic       inv;
		logic       blk;
		logic       last;
		logic       video;
	} ser_s;

	ser_s s;
	ser_s n;
	logic dot;

	always_comb begin
		n = s;
		if (load_in) begin
			n.sh   = visible_in ? {pattern_in, 3'h0} : 10'h000; // RL20 RL1
			n.vis  = visible_in;
			n.ul   = underline_in;
			n.inv  = inverse_in;
			n.blk  = blink_in;
			n.last = last_scan_in;
		end else if (shift_in) begin
			n.sh = {s.sh[8:0], 1'b0}; // RL20 RL3
		end
		dot = n.sh[9];
		if (n.ul && n.last) begin
			dot = 1'b1; // RL23
		end
		if (n.blk) begin
			dot = dot & blink_phase_in; // RL24
		end
		if (n.inv) begin
			dot = ~dot; // RL25
		end
		// Retrace stays black even under inverse
		n.video = dot & n.vis; // RL25
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign video_out = s.video;

endmodule : video_serializer

// ===== verilog/crt_refresh.sv
/*
 Character display refresh: dot, character, scan and row timing, display
 address counters, pair fetch buffer, character generator addressing,
 field modifier latch and sync outputs.
 Assumes display memory and character generator answer on this clock:
 memory data in the same clock as mem_rd_out, generator data combinationally.
*/
// Overview of operation
// [RL1] Cell ten dots by twelve lines
// [RL2] Fixed frame length, same start each frame
// [RL3] Dot counter divides by ten, shifts video
// [RL4] Whole chain from one dot clock
// [RL5] Line is 100 cells, 80 visible
// [RL6] Character counter divides by 100, horizontal drive
// [RL7] Horizontal drive fixed against visible interval
// [RL8] Processor phases come from character counter
// [RL9] Scan counter modulo 12 feeds generator
// [RL10] 310 lines per frame at 60 Hz
// [RL11] 31 rows per frame at 50 Hz
// [RL12] Vertical sync decoded from row counter
// [RL13] Page start loaded at each frame start
// [RL14] Refresh reads in phase one only
// [RL15] Wrap clear at end of memory
// [RL16] Eighty address advances per scan line
// [RL17] Wide mode halves dot clocks only; code also halves shifter loads and, except on the twelfth scan, pair fetches
// [RL18] Wide mode full rate on twelfth scan
// [RL19] Generator address: code high, scan low
// [RL20] Generator dots loaded and shifted out
// [RL21] Fetched pairs buffered, routed one by one
// [RL22] Bit seven set loads attribute latch
// [RL23] Underline forces video on scan 12
// [RL24] Blink ANDs video with blink oscillator
// [RL25] Inverse flips video except in retrace
// [RL26] Attribute cell shows fixed dot pattern
// [RL27] Reset clears counters and attributes
// [RL28] Synchronous counters with enables, no ripple
`timescale 1ns/1ps
module crt_refresh #(
	parameter int BLINK_W = 5
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Register port
	input  wire logic [1:0]  reg_addr_in,
	input  wire logic [15:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [15:0] reg_rdata_out,
	// Display memory, both banks side by side
	output logic      [9:0]  mem_addr_out,
	output logic             mem_rd_out,
	input  wire logic [15:0] mem_data_in,
	// Processor clock phases
	output logic             cpu_phi1_out,
	output logic             cpu_phi2_out,
	// Character generator
	output logic      [10:0] cg_addr_out,
	input  wire logic [7:0]  cg_data_in,
	// Monitor
	output logic             hdrive_out,
	output logic             vsync_out,
	output logic             video_out,
	output logic             dim_out,
	output logic             address_counter_wrap_clear_out
);
	localparam logic [1:0] DOT_CYC_M1 = 2'(crt_refresh_pkg::DOT_CYCLES - 1);

	initial begin
		if (crt_refresh_pkg::DOT_CYCLES > 4) begin
			$error("dot prescaler is two bits wide");
		end
		if (BLINK_W < 1 || BLINK_W > 8) begin
			$error("BLINK_W must lie between 1 and 8");
		end
	end

	typedef struct packed {
		logic [1:0]         pre;
		logic [3:0]         dot;
		logic [6:0]         chr;
		logic [3:0]         scan;
		logic [4:0]         row;
		logic [10:0]        cur;
		logic [10:0]        line_start;
		logic [10:0]        page_start;
		logic               wide;
		logic               hz50;
		logic [15:0]        fetch_buf;
		logic [15:0]        disp_buf;
		logic [10:0]        cg_addr;
		logic               attr_ul;
		logic               attr_inv;
		logic               attr_dim;
		logic               attr_blink;
		logic               attr_cell;
		logic [BLINK_W-1:0] blink_cnt;
		logic               hdrive;
		logic               vsync;
		logic               phi1;
		logic               mem_rd;
		logic [9:0]         mem_addr;
		logic               wrap_clr;
		logic [15:0]        rdata;
		logic               load;
		logic [6:0]         pattern;
		logic               cell_vis;
		logic               last_scan;
		logic               shift;
	} refresh_s;

	refresh_s s;
	refresh_s n;

	logic       dot_tick;
	logic       cell_end;
	logic       line_end;
	logic       frame_end;
	logic       full_rate;
	logic       fetch_slot;
	logic       xfer_slot;
	logic       sel_high;
	logic [7:0] sel_byte;
	logic [6:0] next_cell;
	logic [4:0] row_last;
	logic [3:0] scan_frame_last;
	logic [4:0] vs_row;

	function automatic logic in_range7(input logic [6:0] v, input logic [6:0] lo,
	                                   input logic [6:0] hi);
		in_range7 = (v >= lo) && (v <= hi);
	endfunction : in_range7

	always_comb begin
		n = s;
		n.mem_rd   = 1'b0;
		n.wrap_clr = 1'b0;
		n.load     = 1'b0;

		// One dot every DOT_CYCLES clocks; all slower stages run on enables
		dot_tick = (s.pre == DOT_CYC_M1); // RL4 RL28
		n.pre    = dot_tick ? 2'h0 : 2'(s.pre + 2'h1);

		cell_end  = dot_tick && (s.dot == crt_refresh_pkg::DOT_LAST); // RL3
		line_end  = cell_end && (s.chr == crt_refresh_pkg::CHR_LAST); // RL5 RL6
		row_last  = s.hz50 ? crt_refresh_pkg::ROW_LAST_50 : crt_refresh_pkg::ROW_LAST_60;
		scan_frame_last = s.hz50 ? crt_refresh_pkg::SCAN_LAST : crt_refresh_pkg::SCAN_LAST_60;
		// Frame length is fixed for each hz50 setting, so each frame starts at the same spot
		frame_end = line_end && (s.row == row_last) && (s.scan == scan_frame_last); // RL2 RL10 RL11
		vs_row    = s.hz50 ? crt_refresh_pkg::VS_ROW_50 : crt_refresh_pkg::VS_ROW_60;

		// Timing chain
		if (dot_tick) begin
			n.dot = cell_end ? 4'h0 : 4'(s.dot + 4'h1); // RL3
		end
		if (cell_end) begin
			n.chr = line_end ? 7'h00 : 7'(s.chr + 7'h01); // RL6
		end
		if (line_end) begin
			if (frame_end || s.scan == crt_refresh_pkg::SCAN_LAST) begin
				n.scan = 4'h0; // RL9 RL1
			end else begin
				n.scan = 4'(s.scan + 4'h1);
			end
			if (frame_end) begin
				n.row = 5'h00; // RL10 RL11
			end else if (s.scan == crt_refresh_pkg::SCAN_LAST) begin
				n.row = 5'(s.row + 5'h01);
			end
		end

		// Processor phase one on even cells: refresh owns the memory then
		n.phi1   = ~n.chr[0]; // RL8 RL14
		n.hdrive = in_range7(n.chr, crt_refresh_pkg::HD_FIRST, crt_refresh_pkg::HD_LAST); // RL7
		n.vsync  = (n.row == vs_row) && (n.scan < crt_refresh_pkg::VS_SCANS); // RL12

		// Wide mode uses every fourth cell except on the last scan of a row
		full_rate  = !s.wide || (s.scan == crt_refresh_pkg::SCAN_LAST); // RL18
		fetch_slot = full_rate ? (s.chr[0] == 1'b0) : (s.chr[1:0] == 2'h0);
		xfer_slot  = full_rate ? (s.chr[0] == 1'b1) : (s.chr[1:0] == 2'h1);

		// Pair fetch in phase one; counter steps by one pair per fetch
		if (dot_tick && s.dot == crt_refresh_pkg::DOT_FETCH && fetch_slot &&
		    s.chr < crt_refresh_pkg::VIS_CHARS && s.row < crt_refresh_pkg::VIS_ROWS) begin
			n.mem_rd   = 1'b1; // RL14
			n.mem_addr = s.cur[10:1];
			if (s.cur == crt_refresh_pkg::MEM_LAST_PAIR) begin
				n.cur      = 11'h000; // RL15
				n.wrap_clr = 1'b1; // RL15
			end else begin
				n.cur = 11'(s.cur + 11'h002); // RL16 RL18
			end
		end
		if (s.mem_rd) begin
			n.fetch_buf = mem_data_in; // RL21
		end
		if (dot_tick && s.dot == crt_refresh_pkg::DOT_XFER && xfer_slot) begin
			n.disp_buf = s.fetch_buf; // RL21
		end

		// Pick the byte for the next cell and address the generator
		sel_high = s.wide ? (s.chr[1] == s.chr[0]) : ~s.chr[0]; // RL21 RL17
		sel_byte = sel_high ? s.disp_buf[15:8] : s.disp_buf[7:0];
		if (dot_tick && s.dot == crt_refresh_pkg::DOT_CGA) begin
			n.cg_addr = {sel_byte[6:0], s.scan}; // RL19 RL9
			if (sel_byte[crt_refresh_pkg::ATTR_FLAG_BIT]) begin
				n.attr_ul    = sel_byte[crt_refresh_pkg::ATTR_UL_BIT]; // RL22
				n.attr_inv   = sel_byte[crt_refresh_pkg::ATTR_INV_BIT];
				n.attr_dim   = sel_byte[crt_refresh_pkg::ATTR_DIM_BIT];
				n.attr_blink = sel_byte[crt_refresh_pkg::ATTR_BLINK_BIT];
				n.attr_cell  = 1'b1; // RL26
			end else begin
				n.attr_cell  = 1'b0;
			end
		end

		// Load the shifter for the next cell; wide cells span two cells
		next_cell = 7'(s.chr + 7'h01);
		if (cell_end && (!s.wide || s.chr[0])) begin
			n.load      = 1'b1; // RL17 RL20
			// Generator output is ignored in an attribute cell
			n.pattern   = s.attr_cell ? crt_refresh_pkg::ATTR_PATTERN : cg_data_in[6:0]; // RL26
			n.cell_vis  = in_range7(next_cell, crt_refresh_pkg::FIRST_VIS,
			                        crt_refresh_pkg::LAST_VIS) &&
			              (s.row < crt_refresh_pkg::VIS_ROWS); // RL5 RL25
			n.last_scan = (s.scan == crt_refresh_pkg::SCAN_LAST); // RL23
		end

		// Address counters per scan line and per frame
		if (line_end) begin
			if (frame_end) begin
				n.cur        = s.page_start; // RL13
				n.line_start = s.page_start; // RL13
				n.attr_ul    = 1'b0;
				n.attr_inv   = 1'b0;
				n.attr_dim   = 1'b0;
				n.attr_blink = 1'b0;
				n.blink_cnt  = BLINK_W'(s.blink_cnt + 1'b1);
			end else if (s.scan == crt_refresh_pkg::SCAN_LAST) begin
				n.line_start = s.cur; // RL18
			end else begin
				n.cur = s.line_start; // RL16
			end
		end

		// Register port
		if (reg_wr_in) begin
			if (reg_addr_in == crt_refresh_pkg::REG_CTRL) begin
				n.wide = reg_wdata_in[crt_refresh_pkg::CTRL_WIDE_BIT]; // RL17
				n.hz50 = reg_wdata_in[crt_refresh_pkg::CTRL_HZ50_BIT]; // RL11
			end else if (reg_addr_in == crt_refresh_pkg::REG_PAGE) begin
				n.page_start = reg_wdata_in[10:0]; // RL13
			end
		end
		if (reg_rd_in) begin
			if (reg_addr_in == crt_refresh_pkg::REG_CTRL) begin
				n.rdata = {14'h0000, s.hz50, s.wide};
			end else if (reg_addr_in == crt_refresh_pkg::REG_PAGE) begin
				n.rdata = {5'h00, s.page_start};
			end else if (reg_addr_in == crt_refresh_pkg::REG_STATUS) begin
				n.rdata = {(s.row >= crt_refresh_pkg::VIS_ROWS), 3'h0, s.scan, 3'h0, s.row};
			end else begin
				n.rdata = 16'h0000;
			end
		end else begin
			n.rdata = 16'h0000;
		end

		// Half speed dots in wide mode: shift on every other dot. Registered so the
		// strike trails the tick by one clock like the load does; else the first
		// dot of every cell comes out one clock short
		n.shift = dot_tick && (!s.wide || s.dot[0]); // RL17 RL3
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			s            <= '0; // RL27
			s.wide       <= crt_refresh_pkg::CTRL_WIDE_RESET;
			s.hz50       <= crt_refresh_pkg::CTRL_HZ50_RESET;
			s.page_start <= crt_refresh_pkg::PAGE_RESET;
		end else begin
			s <= n;
		end
	end

	video_serializer u_ser (
		.clk_in         (clk_in),
		.rst_n_in       (rst_n_in),
		.load_in        (s.load),
		.shift_in       (s.shift),
		.pattern_in     (s.pattern),
		.visible_in     (s.cell_vis),
		.underline_in   (s.attr_ul),
		.inverse_in     (s.attr_inv),
		.blink_in       (s.attr_blink),
		.last_scan_in   (s.last_scan),
		.blink_phase_in (s.blink_cnt[BLINK_W-1]),
		.video_out      (video_out)
	);

	assign reg_rdata_out  = s.rdata;
	assign mem_addr_out   = s.mem_addr;
	assign mem_rd_out     = s.mem_rd;
	assign cpu_phi1_out   = s.phi1;
	assign cpu_phi2_out   = ~s.phi1;
	assign cg_addr_out    = s.cg_addr;
	assign hdrive_out     = s.hdrive;
	assign vsync_out      = s.vsync;
	assign dim_out        = s.attr_dim;
	assign address_counter_wrap_clear_out = s.wrap_clr;

endmodule : crt_refresh

// ===== tb/crt_refresh_monitor.sv
/*
 Assertion checker for the character display refresh block.
 Assumes it is bound into crt_refresh and sees only that module's ports.
*/
`timescale 1ns/1ps
module crt_refresh_monitor (
	// Clock and reset
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	// Register port
	input wire logic [1:0]  reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	// Timing and video
	input wire logic [9:0]  mem_addr_out,
	input wire logic        mem_rd_out,
	input wire logic        cpu_phi1_out,
	input wire logic        cpu_phi2_out,
	input wire logic [10:0] cg_addr_out,
	input wire logic        hdrive_out,
	input wire logic        vsync_out,
	input wire logic        video_out,
	input wire logic        address_counter_wrap_clear_out
);
	logic        hd_q;
	logic        hd_seen;
	logic        wide;
	logic [7:0]  hd_cnt;
	logic [11:0] ln_cnt;
	logic [6:0]  rd_cnt;
	logic [6:0]  gap;
	logic [9:0]  last_addr;

	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_line_start;
		hdrive_out && !hd_q;
	endsequence

	// Wide flag mirrored from writes; the gap check needs to know the fetch rate
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			hd_q <= 1'b0;
			hd_seen <= 1'b0;
			wide <= 1'b0;
			hd_cnt <= 8'h0;
			ln_cnt <= 12'h0;
			rd_cnt <= 7'h0;
			gap <= 7'h0;
			last_addr <= 10'h0;
		end else begin
			hd_q <= hdrive_out;
			hd_seen <= hd_seen | (hdrive_out & ~hd_q);
			if (reg_wr_in && reg_addr_in == 2'h0) begin
				wide <= reg_wdata_in[0];
			end
			hd_cnt <= hdrive_out ? hd_cnt + 8'h1 : 8'h0;
			ln_cnt <= (hdrive_out && !hd_q) ? 12'h1 : ln_cnt + 12'h1;
			rd_cnt <= (hdrive_out && !hd_q) ? 7'h0 : rd_cnt + {6'h0, mem_rd_out};
			gap <= mem_rd_out ? 7'h1 : ((gap == 7'h7f) ? gap : gap + 7'h1);
			if (mem_rd_out) begin
				last_addr <= mem_addr_out;
			end
		end
	end

	a_phase_split: assert property (cpu_phi2_out != cpu_phi1_out)
		else $error("processor phases not complementary");
	a_fetch_phase: assert property (mem_rd_out |-> cpu_phi1_out)
		else $error("refresh fetch outside phase one");
	a_hdrive_width: assert property ($fell(hdrive_out) |-> hd_cnt == 8'ha0)
		else $error("horizontal drive not eight cells wide");
	a_line_period: assert property (s_line_start ##0 hd_seen |-> ln_cnt == 12'h7d0)
		else $error("scan line not one hundred cells long");
	a_fetch_count: assert property (s_line_start |-> rd_cnt inside {7'h0, 7'h14, 7'h28})
		else $error("wrong number of pair fetches in a line");
	a_fetch_step: assert property (mem_rd_out && rd_cnt != 7'h0 |->
		mem_addr_out == last_addr + 10'h1)
		else $error("pair address did not advance by one");
	a_fetch_gap: assert property (mem_rd_out && rd_cnt != 7'h0 |->
		gap == 7'h28 || (wide && gap == 7'h50))
		else $error("pair fetch spacing wrong");
	a_video_retrace: assert property (hdrive_out |-> !video_out)
		else $error("video lit during retrace");
	a_scan_range: assert property (cg_addr_out[3:0] <= 4'hb)
		else $error("scan index beyond twelve lines");
	a_wrap_pulse: assert property (address_counter_wrap_clear_out |=>
		!address_counter_wrap_clear_out)
		else $error("wrap clear longer than one clock");
	a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0)
		else $error("read data outside read answer");
	a_unmapped_read: assert property (reg_rd_in && reg_addr_in == 2'h3 |=> reg_rdata_out == 16'h0)
		else $error("unmapped read not zero");
	a_vsync_blank: assert property (mem_rd_out |-> !vsync_out)
		else $error("vertical sync during visible rows");
endmodule : crt_refresh_monitor

bind crt_refresh crt_refresh_monitor mon (
	.clk_in(clk_in),
	.rst_n_in(rst_n_in),
	.reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in),
	.reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out),
	.mem_addr_out(mem_addr_out),
	.mem_rd_out(mem_rd_out),
	.cpu_phi1_out(cpu_phi1_out),
	.cpu_phi2_out(cpu_phi2_out),
	.cg_addr_out(cg_addr_out),
	.hdrive_out(hdrive_out),
	.vsync_out(vsync_out),
	.video_out(video_out),
	.address_counter_wrap_clear_out(address_counter_wrap_clear_out)
);

// ===== tb/crt_far_side_model.sv
/*
 Far-side model: display memory pair port and character generator.
 Assumes a one-clock read strobe with the pair expected while the strobe is high.
*/
`timescale 1ns/1ps
module crt_far_side_model (
	// Clock
	input  wire logic        clk_in,
	// Display memory
	input  wire logic [9:0]  mem_addr_in,
	input  wire logic        mem_rd_in,
	input  wire logic [7:0]  attr_in,
	output logic      [15:0] mem_data_out,
	// Character generator
	input  wire logic [10:0] cg_addr_in,
	output logic      [7:0]  cg_data_out
);
	logic [15:0] churn = 16'h0;

	// The pair must stand while the strobe does, since the edge closing it takes it.
	// Outside the read slot the processor owns the bus, so show churn, not stale data
	always @(posedge clk_in) begin
		churn <= ~churn;
	end
	assign mem_data_out = mem_rd_in ?
	                      {8'h42, (mem_addr_in == 10'h2) ? attr_in : 8'h41} :
	                      churn;
	// Every glyph row lights dots 6, 4, 2 and 0; unused bit 7 toggles
	assign cg_data_out = {cg_addr_in[4], 7'h55};
endmodule : crt_far_side_model

// ===== tb/tb_crt_refresh.sv
/*
 Testbench for the refresh block: register access, line timing, fetch
 addresses, glyph addressing, attribute cells and wide mode.
 Assumes the far-side model answers memory and generator requests.
*/
`timescale 1ns/1ps
module tb_crt_refresh;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [1:0]  reg_addr_in = 2'h0;
	logic [15:0] reg_wdata_in = 16'h0;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic [15:0] reg_rdata_out;
	logic [9:0]  mem_addr_out;
	logic        mem_rd_out;
	logic [15:0] mem_data_in;
	logic [10:0] cg_addr_out;
	logic [7:0]  cg_data_in;
	logic        hdrive_out;
	logic        video_out;
	logic        dim_out;
	logic [7:0]  attr = 8'h41;
	logic        h_q = 1'b0;
	logic        v_q = 1'b0;
	logic [10:0] cg_snap;
	int          hi, rise, n_hi, n_rise, cyc, n_fail, checks, er, eh;
	event        hd_ev;

	always #10 clk_in = ~clk_in;

	crt_refresh #(.BLINK_W(1)) dut (
		.clk_in(clk_in), .rst_n_in(rst_n_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out), .mem_data_in(mem_data_in),
		.cpu_phi1_out(), .cpu_phi2_out(),
		.cg_addr_out(cg_addr_out), .cg_data_in(cg_data_in),
		.hdrive_out(hdrive_out), .vsync_out(), .video_out(video_out), .dim_out(dim_out),
		.address_counter_wrap_clear_out()
	);

	crt_far_side_model far (
		.clk_in(clk_in), .mem_addr_in(mem_addr_out), .mem_rd_in(mem_rd_out),
		.attr_in(attr), .mem_data_out(mem_data_in),
		.cg_addr_in(cg_addr_out), .cg_data_out(cg_data_in)
	);

	task automatic test_done;
		if (n_fail == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : test_done

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
		@(posedge clk_in);
	endtask : reg_wr

	task automatic reg_rd(input logic [1:0] a, input logic [15:0] exp);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		@(negedge clk_in);
		chk(reg_rdata_out, exp);
		@(posedge clk_in);
	endtask : reg_rd

	task automatic fetch_at(input logic [9:0] exp);
		int n;
		n = 0;
		while (mem_rd_out !== 1'b1 && n < 2000) begin
			@(negedge clk_in);
			n++;
		end
		chk({6'h0, mem_addr_out}, {6'h0, exp});
	endtask : fetch_at

	// Lit clocks and dot rises are counted between drive pulses, away from edges
	always @(negedge clk_in) begin
		if (!rst_n_in) begin
			hi = 0;
			rise = 0;
		end else begin
			if (hdrive_out && !h_q) begin
				n_hi = hi;
				n_rise = rise;
				cg_snap = cg_addr_out;
				-> hd_ev;
			end
			if (hdrive_out) begin
				hi = 0;
				rise = 0;
			end else begin
				hi += video_out;
				rise += (video_out && !v_q);
			end
		end
		h_q = hdrive_out;
		v_q = video_out;
	end

	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			test_done();
		end
	end

	initial begin
		repeat (6) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		reg_rd(2'h0, 16'h0);
		reg_rd(2'h1, 16'h0);
		reg_wr(2'h1, 16'hfd50);
		reg_rd(2'h1, 16'h0550);
		reg_wr(2'h1, 16'h0);
		reg_wr(2'h3, 16'hffff);
		reg_rd(2'h3, 16'h0);
		reg_wr(2'h0, 16'h0002);
		reg_rd(2'h0, 16'h0002);
		reg_wr(2'h0, 16'h0);
		for (int k = 0; k < 14; k++) begin
			@(hd_ev);
			er = (k < 3) ? 320 : (k < 5) ? 317 : (k < 11) ? 157 : 160;
			eh = (k < 3) ? 640 : (k < 5) ? 636 : (k < 11) ? 632 : 640;
			// Wide scan 11 uses full-rate fetches and its video is not defined
			if (k != 11) begin
				chk(16'(n_rise), 16'(er));
				chk(16'(n_hi), 16'(eh));
				chk({5'h0, cg_snap}, {5'h0, 7'h41, 4'(k % 12)});
			end
			chk({15'h0, dim_out}, {15'h0, 1'(k > 2)});
			@(posedge clk_in);
			reg_rd(2'h2, 16'(((k % 12) << 8) | (k / 12)));
			if (k == 2) begin
				attr <= 8'h88;
			end
			if (k == 4) begin
				reg_wr(2'h0, 16'h0001);
			end
			if (k == 0) begin
				fetch_at(10'h0);
			end
			if (k == 11) begin
				fetch_at(10'h28);
			end
		end
		test_done();
	end
endmodule : tb_crt_refresh
